// ---- logic/reset_entry_params.svh ----
// timing counts and pin default values for the reset entry block
`ifndef RESET_ENTRY_PARAMS_SVH
`define RESET_ENTRY_PARAMS_SVH
`define RELEASE_TIME_NS 640
`define CLK_PERIOD_NS 20
`define RELEASE_CYCLES ((`RELEASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_STAGES 2
`define MODE_RESET_VALUE 1'b0
`define SCI_SEL_RESET 1'b1
`define SPI_CLK_SEL_RESET 1'b1
`define SRX_CLK_SEL_RESET 1'b0
`define GPIO_DIR_RESET 1'b0
`endif

// ---- logic/reset_entry_pkg.sv ----
// types shared by the reset entry block
`default_nettype none
package reset_entry_pkg;
  typedef enum logic [1:0] {ST_HELD, ST_COUNT, ST_RUN} rst_state_e;
  typedef struct packed {
    logic sel_periph;
    logic gpio_dir_out;
    logic gpio_out;
  } pin_cfg_s;
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_s;
endpackage
`default_nettype wire

// ---- logic/pin_sync.sv ----
// two flip-flop synchroniser for a vector of asynchronous inputs
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ---- logic/reset_entry.sv ----
// reset entry sequencer and shared pin defaults
`include "reset_entry_params.svh"
`default_nettype none
module reset_entry #(
  parameter int RELEASE_CYCLES = `RELEASE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic chip_reset_pin_n,
  input wire logic test_reset_pin_n,
  input wire logic boot_mode_pin,
  input wire reset_entry_pkg::pin_cfg_s sci0_cfg,
  input wire reset_entry_pkg::pin_cfg_s sci1_cfg,
  input wire reset_entry_pkg::pin_cfg_s spi_clk_cfg,
  input wire reset_entry_pkg::pin_cfg_s srx_clk_cfg,
  input wire logic cfg_write,
  input wire logic spi_master,
  input wire logic spi_clk_out,
  input wire logic [3:0] pin_in,
  output logic core_reset_n,
  output logic debug_reset_n,
  output logic boot_mode,
  output logic sci_sel_q_out,
  output reset_entry_pkg::pin_drive_s sci0_receive_in_drv,
  output reset_entry_pkg::pin_drive_s sci1_receive_in_drv,
  output reset_entry_pkg::pin_drive_s port_f_bit4_drv,
  output reset_entry_pkg::pin_drive_s port_c_bit2_drv,
  output logic [3:0] pin_sync_val
);
  localparam int CW = $clog2(RELEASE_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(RELEASE_CYCLES - 1);

  // the boot pin rides the same synchroniser, so it is latched in step with the reset release
  logic [6:0] sync_vec;
  pin_sync #(.WIDTH(7)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in({chip_reset_pin_n, test_reset_pin_n, boot_mode_pin, pin_in}),
    .sync_out(sync_vec)
  );
  logic chip_rst_s;
  logic test_rst_s;
  logic boot_s;
  assign chip_rst_s = sync_vec[6];
  assign test_rst_s = sync_vec[5];
  assign boot_s = sync_vec[4];

  reset_entry_pkg::rst_state_e state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic core_rst_n_q, core_rst_n_d;
  logic dbg_rst_n_q, dbg_rst_n_d;
  logic mode_q, mode_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    core_rst_n_d = 1'b0;
    mode_d = mode_q;
    dbg_rst_n_d = test_rst_s;
    unique case (state_q)
      reset_entry_pkg::ST_HELD: begin
        if (chip_rst_s) begin
          mode_d = boot_s;
          cnt_d = '0;
          state_d = reset_entry_pkg::ST_COUNT;
        end
      end
      reset_entry_pkg::ST_COUNT: begin
        if (!chip_rst_s) begin
          state_d = reset_entry_pkg::ST_HELD;
        end else if (cnt_q == CNT_LAST) begin
          state_d = reset_entry_pkg::ST_RUN;
          core_rst_n_d = 1'b1;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      reset_entry_pkg::ST_RUN: begin
        core_rst_n_d = chip_rst_s;
        if (!chip_rst_s) begin
          state_d = reset_entry_pkg::ST_HELD;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= reset_entry_pkg::ST_HELD;
      cnt_q <= '0;
      core_rst_n_q <= 1'b0;
      dbg_rst_n_q <= 1'b0;
      mode_q <= `MODE_RESET_VALUE;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      core_rst_n_q <= core_rst_n_d;
      dbg_rst_n_q <= dbg_rst_n_d;
      mode_q <= mode_d;
    end
  end

  // pin configuration: defaults return whenever the core is in reset
  reset_entry_pkg::pin_cfg_s sci0_q, sci0_d, sci1_q, sci1_d;
  reset_entry_pkg::pin_cfg_s spck_q, spck_d, sync_serial_rx_clock_q, sync_serial_rx_clock_d;
  localparam reset_entry_pkg::pin_cfg_s SCI_DEF = '{`SCI_SEL_RESET, `GPIO_DIR_RESET, 1'b0};
  localparam reset_entry_pkg::pin_cfg_s SPCK_DEF = '{`SPI_CLK_SEL_RESET, `GPIO_DIR_RESET, 1'b0};
  localparam reset_entry_pkg::pin_cfg_s SYNC_SERIAL_RX_CLOCK_DEF = '{`SRX_CLK_SEL_RESET, `GPIO_DIR_RESET, 1'b0};

  always_comb begin
    sci0_d = sci0_q;
    sci1_d = sci1_q;
    spck_d = spck_q;
    sync_serial_rx_clock_d = sync_serial_rx_clock_q;
    if (!core_rst_n_q) begin
      sci0_d = SCI_DEF;
      sci1_d = SCI_DEF;
      spck_d = SPCK_DEF;
      sync_serial_rx_clock_d = SYNC_SERIAL_RX_CLOCK_DEF;
    end else if (cfg_write) begin
      sci0_d = sci0_cfg;
      sci1_d = sci1_cfg;
      spck_d = spi_clk_cfg;
      sync_serial_rx_clock_d = srx_clk_cfg;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sci0_q <= SCI_DEF;
      sci1_q <= SCI_DEF;
      spck_q <= SPCK_DEF;
      sync_serial_rx_clock_q <= SYNC_SERIAL_RX_CLOCK_DEF;
    end else begin
      sci0_q <= sci0_d;
      sci1_q <= sci1_d;
      spck_q <= spck_d;
      sync_serial_rx_clock_q <= sync_serial_rx_clock_d;
    end
  end

  function automatic reset_entry_pkg::pin_drive_s gpio_drive(
    input reset_entry_pkg::pin_cfg_s c);
    reset_entry_pkg::pin_drive_s r;
    r.out = c.gpio_out;
    r.oe = ~c.sel_periph & c.gpio_dir_out;
    return r;
  endfunction

  // pin drives registered so every output comes from a flip-flop
  reset_entry_pkg::pin_drive_s d0_q, d0_d, d1_q, d1_d, d2_q, d2_d, d3_q, d3_d;
  logic [3:0] pv_q, pv_d;
  always_comb begin
    d0_d = gpio_drive(sci0_q); // sci mode is input only
    d1_d = gpio_drive(sci1_q);
    d3_d = gpio_drive(sync_serial_rx_clock_q);
    pv_d = sync_vec[3:0];
    if (spck_q.sel_periph) begin
      d2_d.out = spi_clk_out;
      d2_d.oe = spi_master;
    end else begin
      d2_d = gpio_drive(spck_q);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      d0_q <= '0;
      d1_q <= '0;
      d2_q <= '0;
      d3_q <= '0;
      pv_q <= '0;
    end else begin
      d0_q <= d0_d;
      d1_q <= d1_d;
      d2_q <= d2_d;
      d3_q <= d3_d;
      pv_q <= pv_d;
    end
  end

  assign core_reset_n = core_rst_n_q;
  assign debug_reset_n = dbg_rst_n_q;
  assign boot_mode = mode_q;
  assign sci_sel_q_out = sci0_q.sel_periph;
  assign sci0_receive_in_drv = d0_q;
  assign sci1_receive_in_drv = d1_q;
  assign port_f_bit4_drv = d2_q;
  assign port_c_bit2_drv = d3_q;
  assign pin_sync_val = pv_q;

  property p_hold_in_reset;
    @(posedge ref_clk) disable iff (!reset_n)
    !chip_rst_s |=> !core_reset_n;
  endproperty
  a_hold_in_reset: assert property (p_hold_in_reset) else $error("core left reset");

  property p_release_count;
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(core_reset_n) |-> $past(state_q) == reset_entry_pkg::ST_COUNT;
  endproperty
  a_release_count: assert property (p_release_count) else $error("release without count");

  property p_mode_latch;
    @(posedge ref_clk) disable iff (!reset_n)
    (state_q == reset_entry_pkg::ST_HELD && chip_rst_s) |=> boot_mode == $past(boot_s);
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("mode not latched");

  property p_debug_kept;
    @(posedge ref_clk) disable iff (!reset_n)
    (test_rst_s && !chip_rst_s) |=> debug_reset_n;
  endproperty
  a_debug_kept: assert property (p_debug_kept) else $error("debug reset by chip reset");

  property p_defaults;
    @(posedge ref_clk) disable iff (!reset_n)
    !core_reset_n |=> sci0_q.sel_periph && sci1_q.sel_periph && spck_q.sel_periph
      && !sync_serial_rx_clock_q.sel_periph && !sync_serial_rx_clock_q.gpio_dir_out;
  endproperty
  a_defaults: assert property (p_defaults) else $error("pin default lost");

  property p_spi_clk_dir;
    @(posedge ref_clk) disable iff (!reset_n)
    spck_q.sel_periph |=> port_f_bit4_drv.oe == $past(spi_master);
  endproperty
  a_spi_clk_dir: assert property (p_spi_clk_dir) else $error("spi clock dir wrong");

  property p_gpio_dir;
    @(posedge ref_clk) disable iff (!reset_n)
    !sync_serial_rx_clock_q.sel_periph |=> port_c_bit2_drv.oe == $past(sync_serial_rx_clock_q.gpio_dir_out);
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("gpio dir wrong");

  property p_sync_delay;
    @(posedge ref_clk) disable iff (!reset_n)
    !chip_reset_pin_n [*3] |=> !core_reset_n;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync path wrong");
endmodule
`default_nettype wire

// ---- test/reset_board_model.sv ----
// board reset supervisor and debugger model driving both reset pins
`default_nettype none
module reset_board_model (
  input wire logic ref_clk,
  input wire logic full_req,
  input wire logic core_req,
  output logic chip_reset_pin_n,
  output logic test_reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    chip_reset_pin_n = 1'b0;
    test_reset_pin_n = 1'b0;
  end
  // a full reset pulls both pins together; a debugger pulls the chip pin only
  always @(negedge ref_clk) begin
    chip_reset_pin_n <= !(full_req || core_req);
    test_reset_pin_n <= !full_req;
  end
endmodule
`default_nettype wire

// ---- test/reset_entry_tb_top.sv ----
// self-checking bench for the reset entry sequencer
`default_nettype none
module reset_entry_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RC = 4;
  logic ref_clk, reset_n, chip_n, test_n, boot_pin, cfg_write, spi_master, spi_clk_out;
  logic full_req, core_req, core_reset_n, debug_reset_n, boot_mode, sci_sel;
  reset_entry_pkg::pin_cfg_s cfg0, cfg1, cfgc, cfgs;
  reset_entry_pkg::pin_drive_s d0, d1, df4, dc2;
  logic [3:0] pin_in, pin_sync_val;
  int num_errors = 0;
  int n_tests = 0;
  reset_board_model reset_board_model_i (.ref_clk(ref_clk), .full_req(full_req),
    .core_req(core_req), .chip_reset_pin_n(chip_n), .test_reset_pin_n(test_n));
  reset_entry #(.RELEASE_CYCLES(RC)) reset_entry_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .chip_reset_pin_n(chip_n), .test_reset_pin_n(test_n), .boot_mode_pin(boot_pin),
    .sci0_cfg(cfg0), .sci1_cfg(cfg1), .spi_clk_cfg(cfgc), .srx_clk_cfg(cfgs),
    .cfg_write(cfg_write), .spi_master(spi_master), .spi_clk_out(spi_clk_out),
    .pin_in(pin_in), .core_reset_n(core_reset_n), .debug_reset_n(debug_reset_n),
    .boot_mode(boot_mode), .sci_sel_q_out(sci_sel), .sci0_receive_in_drv(d0),
    .sci1_receive_in_drv(d1), .port_f_bit4_drv(df4), .port_c_bit2_drv(dc2),
    .pin_sync_val(pin_sync_val));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hold a reset, try a refused cfg write, release and time the core release
  task automatic rel(input logic full, input logic boot);
    int cnt;
    cnt = 0;
    full_req <= full;
    core_req <= !full;
    boot_pin <= boot;
    cyc(5);
    chk(core_reset_n, 0, "core out of reset while pin low");
    chk(debug_reset_n, !full, "debug reset level");
    cfg_write <= 1'b1;
    cyc(1);
    cfg_write <= 1'b0;
    full_req <= 1'b0;
    core_req <= 1'b0;
    while (core_reset_n !== 1'b1) begin
      cyc(1);
      cnt++;
      if (cnt > 40) begin
        num_errors++;
        results();
      end
    end
    // model lag 1, two sync stages, one cycle to start counting, then RC counts
    chk(cnt == RC + 4, 1, "release count");
    boot_pin <= !boot;
    cyc(3);
    chk(boot_mode, boot, "boot mode latch");
    chk(debug_reset_n, 1, "debug reset held");
    chk(sci_sel, 1, "sci select default");
    chk(d0.oe, 0, "sci0 default input");
    chk(d1.oe, 0, "sci1 default input");
    chk(df4, {spi_clk_out, 1'b1}, "spi clock default");
    chk(dc2.oe, 0, "ssi clock default gpio input");
    $display("reset test done, full %0d", full);
  endtask
  // a short chip reset pulse in mid-count must restart the release count
  task automatic t_abort();
    int cnt;
    cnt = 0;
    core_req <= 1'b1;
    cyc(6);
    core_req <= 1'b0;
    cyc(3);
    core_req <= 1'b1;
    cyc(2);
    chk(core_reset_n, 0, "core left reset in aborted count");
    core_req <= 1'b0;
    while (core_reset_n !== 1'b1) begin
      cyc(1);
      cnt++;
      if (cnt > 40) begin
        num_errors++;
        results();
      end
    end
    chk(cnt == RC + 4, 1, "count restarted after abort");
    chk(debug_reset_n, 1, "debug kept through core pulse");
    $display("abort test done");
  endtask
  task automatic t_gpio();
    cfg_write <= 1'b1;
    cyc(1);
    cfg_write <= 1'b0;
    cyc(3);
    chk(d0, 2'b11, "sci0 gpio output high");
    chk(d1.oe, 0, "sci1 gpio input");
    chk(df4.oe, 0, "spi pin gpio input");
    chk(dc2, 2'b01, "ssi pin gpio output low");
    $display("gpio test done");
  endtask
  task automatic t_spi();
    cfg0 <= '{1'b1, 1'b0, 1'b0};
    cfgc <= '{1'b1, 1'b0, 1'b0};
    cfg_write <= 1'b1;
    cyc(1);
    cfg_write <= 1'b0;
    spi_master <= 1'b0;
    cyc(3);
    chk(df4.oe, 0, "slave takes clock in");
    spi_master <= 1'b1;
    spi_clk_out <= 1'b0;
    pin_in <= 4'ha;
    cyc(4);
    chk(df4, 2'b01, "master drives clock");
    chk(pin_sync_val, 4'ha, "pin sync value");
    chk(sci_sel, 1, "sci select written");
    $display("spi test done");
  endtask
  initial begin
    reset_n = 1'b0;
    full_req = 1'b1;
    core_req = 1'b0;
    boot_pin = 1'b0;
    cfg_write = 1'b0;
    spi_master = 1'b1;
    spi_clk_out = 1'b1;
    pin_in = 4'h5;
    cfg0 = '{1'b0, 1'b1, 1'b1};
    cfg1 = '{1'b0, 1'b0, 1'b0};
    cfgc = '{1'b0, 1'b0, 1'b0};
    cfgs = '{1'b0, 1'b1, 1'b0};
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n <= 1'b1;
    rel(1'b1, 1'b1);
    rel(1'b0, 1'b0);
    t_abort();
    t_gpio();
    rel(1'b1, 1'b1);
    t_spi();
    results();
  end
endmodule
`default_nettype wire
